// ==== core/sfpc_pkg.sv ====
package sfpc_pkg;

  localparam int INSTR_BITS = 8;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_LAST = 4'h7;
  localparam int SYNC_W = 10;
  // Cs high, reset high, clock low as a mode 0 host idles, supply flags all showing "off"
  localparam logic [SYNC_W-1:0] SYNC_IDLE = 10'h3EF;
  localparam int IO_SI = 0;
  localparam int IO_HOLD = 3;
  localparam logic [3:0] OE_NONE = 4'h0;
  localparam logic [3:0] OE_SO = 4'h2;
  localparam logic [3:0] OE_DUAL = 4'h3;
  localparam logic [3:0] OE_QUAD = 4'hF;
  localparam logic [3:0] DOUT_RST = 4'h0;
  localparam logic [7:0] INSTR_RST = 8'h00;

  typedef enum logic [4:0] {
    PH_STANDBY,
    PH_SINGLE_IN,
    PH_SINGLE_LAT,
    PH_SINGLE_OUT,
    PH_DUAL_IN,
    PH_DUAL_LAT,
    PH_DUAL_OUT,
    PH_QPP_ADDR,
    PH_QUAD_IN,
    PH_QUAD_LAT,
    PH_QUAD_OUT,
    PH_DDR_SINGLE_IN,
    PH_DDR_DUAL_IN,
    PH_DDR_QUAD_IN,
    PH_DDR_LAT,
    PH_DDR_SINGLE_OUT,
    PH_DDR_DUAL_OUT,
    PH_DDR_QUAD_OUT
  } sfpc_phase_t;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_STANDBY,
    ST_INSTR,
    ST_CMD
  } sfpc_state_t;

  typedef struct packed {
    logic hw_rst_n;
    logic cs_n;
    logic sck;
    logic [3:0] io;
  } sfpc_pins_t;

  typedef struct packed {
    logic vcc_low;
    logic vcc_cutoff;
    logic por_busy;
  } sfpc_supply_t;

  typedef struct packed {
    sfpc_supply_t supply;
    sfpc_pins_t pins;
  } sfpc_async_t;

endpackage

// ==== core/sfpc_fifo.sv ====
`timescale 1ns/1ps
module sfpc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] CNT_FULL = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;

  assign o_ready = (cnt_reg != CNT_FULL);
  assign o_valid = (cnt_reg != '0);
  assign o_data = mem_reg[rd_reg];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_reg[wr_reg] <= i_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == PTR_LAST) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == PTR_LAST) ? '0 : rd_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_reg <= '0;
    end else if (push && !pop) begin
      cnt_reg <= cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

endmodule

// ==== core/sfpc_pin_ctrl.sv ====
`timescale 1ns/1ps
// What this block does
// R1: Single input phase: host drives serial input, memory leaves serial output undriven.
// R2: Single output phase: memory drives the serial output line with data.
// R3: Dual input phase: host drives I/O0 and I/O1; memory drives none.
// R4: Dual output phase at single rate: memory drives I/O0 and I/O1.
// R5: Quad page program address phase: only serial input matters; memory drives none.
// R6: Quad input phase: host drives all four lines; memory drives none.
// R7: Quad output phase: memory drives all four lines while selected.
// R8: DDR single input: only serial input is valid; memory drives none.
// R9: DDR dual input: host drives I/O0 and I/O1; memory drives none.
// R10: DDR quad input: host drives all four lines; memory drives none.
// R11: DDR single output: memory drives serial output, I/O2 and I/O3 float.
// R12: DDR dual output: memory drives I/O0 and I/O1, I/O2 and I/O3 float.
// R13: DDR quad output: memory drives all four lines.
// R14: Core supply low: treat as powered off, respond to nothing.
// R15: Powered off: no program or erase may start or run.
// R16: Supply below cut-off: ignore all commands, no program or erase; the code only refuses a new command, one under way runs on.
// R17: Chip select high is standby; its falling edge starts the instruction phase.
// R18: Instruction: eight bits, one per rising clock, most significant first.
// R19: Quad enable clear makes I/O3 the pause input, set makes it data.
// R20: Pause low freezes the command, floats outputs, ignores data inputs; the code takes no pause in DDR phases once the instruction is done.
// R21: Off, low supply, power-on and hardware reset keep serial output undriven.
// R22: Host releases a line before any phase in which memory drives it.
module sfpc_pin_ctrl #(
  parameter int FIFO_DEPTH = 2
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire sfpc_pkg::sfpc_pins_t i_pins,
  input wire sfpc_pkg::sfpc_supply_t i_supply,
  input wire logic i_quad_enable,
  input wire sfpc_pkg::sfpc_phase_t i_phase,
  input wire logic [3:0] i_out_data,
  input wire logic i_pe_request,
  input wire logic i_instr_ready,
  output logic [3:0] o_io_out,
  output logic [3:0] o_io_oe,
  output logic o_out_taken,
  output logic [7:0] o_instr_data,
  output logic o_instr_valid,
  output logic o_instr_active,
  output logic o_hold,
  output logic o_powered,
  output logic o_pe_allowed,
  output logic o_pe_start
);

  function automatic logic [3:0] phase_oe(input sfpc_pkg::sfpc_phase_t ph);
    logic [3:0] oe;
    oe = sfpc_pkg::OE_NONE;
    unique case (ph)
      sfpc_pkg::PH_SINGLE_OUT: oe = sfpc_pkg::OE_SO; // R2
      sfpc_pkg::PH_DUAL_OUT: oe = sfpc_pkg::OE_DUAL; // R4
      sfpc_pkg::PH_QUAD_OUT: oe = sfpc_pkg::OE_QUAD; // R7
      sfpc_pkg::PH_DDR_SINGLE_OUT: oe = sfpc_pkg::OE_SO; // R11
      sfpc_pkg::PH_DDR_DUAL_OUT: oe = sfpc_pkg::OE_DUAL; // R12
      sfpc_pkg::PH_DDR_QUAD_OUT: oe = sfpc_pkg::OE_QUAD; // R13
      // Input, latency and standby phases leave every line to the host
      sfpc_pkg::PH_STANDBY, sfpc_pkg::PH_SINGLE_IN, sfpc_pkg::PH_SINGLE_LAT,
      sfpc_pkg::PH_DUAL_IN, sfpc_pkg::PH_DUAL_LAT, sfpc_pkg::PH_QPP_ADDR,
      sfpc_pkg::PH_QUAD_IN, sfpc_pkg::PH_QUAD_LAT, sfpc_pkg::PH_DDR_SINGLE_IN,
      sfpc_pkg::PH_DDR_DUAL_IN, sfpc_pkg::PH_DDR_QUAD_IN,
      sfpc_pkg::PH_DDR_LAT: oe = sfpc_pkg::OE_NONE; // R1 R3 R5 R6 R8 R9 R10
      default: oe = sfpc_pkg::OE_NONE;
    endcase
    return oe;
  endfunction

  function automatic logic is_ddr(input sfpc_pkg::sfpc_phase_t ph);
    return (ph >= sfpc_pkg::PH_DDR_SINGLE_IN);
  endfunction

  logic [sfpc_pkg::SYNC_W-1:0] s1_reg;
  logic [sfpc_pkg::SYNC_W-1:0] s2_reg;
  logic [sfpc_pkg::SYNC_W-1:0] s3_reg;
  sfpc_pkg::sfpc_async_t filt_reg;
  sfpc_pkg::sfpc_async_t filt_next;
  logic [sfpc_pkg::SYNC_W-1:0] agree;

  sfpc_pkg::sfpc_state_t state_reg;
  sfpc_pkg::sfpc_state_t state_next;
  logic [sfpc_pkg::CNT_W-1:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] pend_data_reg;
  logic pend_reg;
  logic pend_ready;
  logic [3:0] oe_reg;
  logic [3:0] dout_reg;
  logic taken_reg;
  logic allowed_reg;
  logic start_reg;

  logic live;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_high;
  logic hold_now;
  logic out_edge;
  logic instr_done;

  // Three-stage sampling; a change counts once stages two and three agree
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s1_reg <= sfpc_pkg::SYNC_IDLE;
      s2_reg <= sfpc_pkg::SYNC_IDLE;
      s3_reg <= sfpc_pkg::SYNC_IDLE;
      filt_reg <= sfpc_pkg::SYNC_IDLE;
    end else begin
      s1_reg <= {i_supply, i_pins};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      filt_reg <= filt_next;
    end
  end

  assign agree = ~(s2_reg ^ s3_reg);
  assign filt_next = (agree & s3_reg) | (~agree & filt_reg);

  assign sck_rise = filt_next.pins.sck && !filt_reg.pins.sck;
  assign sck_fall = !filt_next.pins.sck && filt_reg.pins.sck;
  assign cs_fall = !filt_next.pins.cs_n && filt_reg.pins.cs_n;
  assign cs_high = filt_reg.pins.cs_n;

  // Off, power-on reset and hardware reset all silence the interface
  assign live = !filt_reg.supply.vcc_low && !filt_reg.supply.por_busy
             && filt_reg.pins.hw_rst_n; // R14 R21
  // Pause only exists while I/O3 is not a data line, and in DDR phases only during the instruction
  assign hold_now = !i_quad_enable && !filt_reg.pins.io[sfpc_pkg::IO_HOLD] && !cs_high
                 && ((state_reg == sfpc_pkg::ST_INSTR) || !is_ddr(i_phase)); // R19
  assign instr_done = sck_rise && !hold_now && (bit_cnt_reg == sfpc_pkg::CNT_LAST);
  assign out_edge = (state_reg == sfpc_pkg::ST_CMD) && !hold_now
                 && (is_ddr(i_phase) ? (sck_rise || sck_fall) : sck_fall);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      sfpc_pkg::ST_OFF: begin
        if (live) begin
          state_next = sfpc_pkg::ST_STANDBY;
        end
      end
      sfpc_pkg::ST_STANDBY: begin
        // Commands below cut-off, or while the last byte is unclaimed, are ignored
        if (cs_fall && !filt_reg.supply.vcc_cutoff && !pend_reg) begin
          state_next = sfpc_pkg::ST_INSTR; // R16 R17
        end
      end
      sfpc_pkg::ST_INSTR: begin
        if (cs_high) begin
          state_next = sfpc_pkg::ST_STANDBY; // R17
        end else if (instr_done) begin
          state_next = sfpc_pkg::ST_CMD;
        end
      end
      sfpc_pkg::ST_CMD: begin
        if (cs_high) begin
          state_next = sfpc_pkg::ST_STANDBY; // R17
        end
      end
    endcase
    if (!live) begin
      state_next = sfpc_pkg::ST_OFF; // R14
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_reg <= sfpc_pkg::ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // Instruction shifter, frozen while paused
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      bit_cnt_reg <= sfpc_pkg::CNT_ZERO;
      shift_reg <= sfpc_pkg::INSTR_RST;
    end else if (state_reg != sfpc_pkg::ST_INSTR) begin
      bit_cnt_reg <= sfpc_pkg::CNT_ZERO;
    end else if (sck_rise && !hold_now) begin
      bit_cnt_reg <= bit_cnt_reg + 1'b1; // R18
      shift_reg <= {shift_reg[6:0], filt_reg.pins.io[sfpc_pkg::IO_SI]}; // R18 R20
    end
  end

  // Completed byte waits here until the buffer takes it
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pend_reg <= 1'b0;
      pend_data_reg <= sfpc_pkg::INSTR_RST;
    end else if (state_reg == sfpc_pkg::ST_INSTR && instr_done && !cs_high && live) begin
      pend_reg <= 1'b1;
      pend_data_reg <= {shift_reg[6:0], filt_reg.pins.io[sfpc_pkg::IO_SI]}; // R18
    end else if (pend_ready) begin
      pend_reg <= 1'b0;
    end
  end

  sfpc_fifo #(
    .WIDTH(sfpc_pkg::INSTR_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_instr_fifo (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_valid(pend_reg),
    .o_ready(pend_ready),
    .i_data(pend_data_reg),
    .o_valid(o_instr_valid),
    .i_ready(i_instr_ready),
    .o_data(o_instr_data)
  );

  // Pin drive: memory drives only in output phases, never while paused or off
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      oe_reg <= sfpc_pkg::OE_NONE;
    end else if (state_next == sfpc_pkg::ST_CMD && state_reg == sfpc_pkg::ST_CMD && !hold_now) begin
      oe_reg <= phase_oe(i_phase); // R2 R4 R7 R11 R12 R13 R22
    end else begin
      oe_reg <= sfpc_pkg::OE_NONE; // R1 R20 R21
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      dout_reg <= sfpc_pkg::DOUT_RST;
      taken_reg <= 1'b0;
    end else begin
      taken_reg <= out_edge && (phase_oe(i_phase) != sfpc_pkg::OE_NONE);
      if (out_edge && (phase_oe(i_phase) != sfpc_pkg::OE_NONE)) begin
        dout_reg <= i_out_data; // R2 R4 R7 R11 R12 R13
      end
    end
  end

  // Program and erase may only start or run with a healthy supply
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      allowed_reg <= 1'b0;
      start_reg <= 1'b0;
    end else begin
      allowed_reg <= live && !filt_reg.supply.vcc_cutoff; // R15 R16
      start_reg <= i_pe_request && live && !filt_reg.supply.vcc_cutoff; // R15 R16
    end
  end

  assign o_io_oe = oe_reg;
  assign o_io_out = dout_reg;
  assign o_out_taken = taken_reg;
  assign o_instr_active = (state_reg == sfpc_pkg::ST_INSTR);
  assign o_hold = hold_now && (state_reg == sfpc_pkg::ST_INSTR || state_reg == sfpc_pkg::ST_CMD);
  assign o_powered = (state_reg != sfpc_pkg::ST_OFF);
  assign o_pe_allowed = allowed_reg;
  assign o_pe_start = start_reg;

endmodule

// ==== core/sfpc_pkg_unused_guard.sv ====
`timescale 1ns/1ps

// ==== dv/sfpc_pin_ctrl_assertions.sv ====
`timescale 1ns/1ps
module sfpc_pin_ctrl_assertions (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire sfpc_pkg::sfpc_pins_t i_pins,
  input wire sfpc_pkg::sfpc_supply_t i_supply,
  input wire logic i_quad_enable,
  input wire sfpc_pkg::sfpc_phase_t i_phase,
  input wire logic i_pe_request,
  input wire logic [3:0] o_io_oe,
  input wire logic o_instr_active,
  input wire logic o_hold,
  input wire logic o_powered,
  input wire logic o_pe_allowed,
  input wire logic o_pe_start
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic ph_in;
  assign ph_in = !(i_phase inside {sfpc_pkg::PH_SINGLE_OUT, sfpc_pkg::PH_DUAL_OUT, sfpc_pkg::PH_QUAD_OUT,
    sfpc_pkg::PH_DDR_SINGLE_OUT, sfpc_pkg::PH_DDR_DUAL_OUT, sfpc_pkg::PH_DDR_QUAD_OUT});
  off_state_a: assert property (i_supply.vcc_low [*7] |-> !o_powered && o_io_oe == 4'h0 && !o_pe_allowed)
    else $error("device active with supply off");
  cutoff_pe_a: assert property (i_supply.vcc_cutoff [*7] |-> !o_pe_allowed && !o_pe_start)
    else $error("program or erase allowed below cut-off");
  pe_start_a: assert property (o_pe_start |-> $past(i_pe_request) && o_pe_allowed)
    else $error("program or erase start without request and permission");
  standby_a: assert property (i_pins.cs_n [*6] |-> o_io_oe == 4'h0 && !o_instr_active)
    else $error("activity while deselected");
  in_float_a: assert property (ph_in [*2] |-> o_io_oe == 4'h0)
    else $error("device drives lines in a non-output phase");
  single_oe_a: assert property (o_io_oe == 4'h2 |-> $past(i_phase) inside {sfpc_pkg::PH_SINGLE_OUT,
    sfpc_pkg::PH_DDR_SINGLE_OUT})
    else $error("single output enable in wrong phase");
  dual_oe_a: assert property (o_io_oe == 4'h3 |-> $past(i_phase) inside {sfpc_pkg::PH_DUAL_OUT,
    sfpc_pkg::PH_DDR_DUAL_OUT})
    else $error("dual output enable in wrong phase");
  quad_oe_a: assert property (o_io_oe == 4'hF |-> $past(i_phase) inside {sfpc_pkg::PH_QUAD_OUT,
    sfpc_pkg::PH_DDR_QUAD_OUT})
    else $error("quad output enable in wrong phase");
  hold_float_a: assert property (o_hold [*2] |-> o_io_oe == 4'h0)
    else $error("outputs driven while paused");
  hold_qe_a: assert property (i_quad_enable [*2] |-> !o_hold)
    else $error("pause taken with quad enable set");
endmodule
bind sfpc_pin_ctrl sfpc_pin_ctrl_assertions sfpc_pin_ctrl_assertions_i (.i_clk, .i_rst_n, .i_pins, .i_supply,
  .i_quad_enable, .i_phase, .i_pe_request, .o_io_oe, .o_instr_active, .o_hold, .o_powered, .o_pe_allowed, .o_pe_start);

// ==== dv/sfpc_host_model.sv ====
`timescale 1ns/1ps
module sfpc_host_model (
  input wire logic [3:0] i_io,
  output logic o_cs_n,
  output logic o_sck,
  output logic [3:0] o_io,
  output logic [3:0] o_io_oe
);
  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_io = 4'h0;
    o_io_oe = 4'h0;
  end
  task automatic set(input logic [3:0] d, input logic [3:0] oe);
    o_io = d;
    o_io_oe = oe;
  endtask
  // Mode 0 clock, low outside frames
  task automatic xfer(input logic [3:0] d, input logic [3:0] oe, output logic [3:0] q);
    set(d, oe);
    #62.5 o_sck = 1'b1;
    q = i_io;
    #62.5 o_sck = 1'b0;
  endtask
  task automatic frame(input logic sel);
    #62.5 o_cs_n = !sel;
    if (!sel) o_io_oe = 4'h0;
  endtask
  // Instruction on io0 MSB first, pause line held high
  task automatic instr(input logic [7:0] b);
    logic [3:0] q;
    for (int k = 7; k >= 0; k--) xfer({3'h7, b[k]}, 4'h9, q);
  endtask
endmodule

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  logic i_clk, i_rst_n, i_quad_enable, i_pe_request, i_instr_ready, o_out_taken, o_instr_valid, o_instr_active;
  logic o_hold, o_powered, o_pe_allowed, o_pe_start, hw_rst_n, h_cs_n, h_sck;
  logic [3:0] i_out_data, o_io_out, o_io_oe, io, h_io, h_oe, q;
  logic [3:0] io_last = 4'h0;
  logic [7:0] o_instr_data, b1, b2;
  logic [31:0] lfsr = 32'h6C05;
  int num_errors = 0;
  int n_checks = 0;
  int n_taken = 0;
  sfpc_pkg::sfpc_pins_t i_pins;
  sfpc_pkg::sfpc_supply_t i_supply;
  sfpc_pkg::sfpc_phase_t i_phase;
  assign i_pins = {hw_rst_n, h_cs_n, h_sck, io};
  // Released lines toggle every cycle
  always_comb for (int k = 0; k < 4; k++)
    io[k] = (o_io_oe[k] === 1'b1) ? o_io_out[k] : (h_oe[k] === 1'b1) ? h_io[k] : ~io_last[k];
  always @(posedge i_clk) io_last <= io;
  sfpc_pin_ctrl sfpc_pin_ctrl_i (.i_clk, .i_rst_n, .i_pins, .i_supply, .i_quad_enable, .i_phase, .i_out_data,
    .i_pe_request, .i_instr_ready, .o_io_out, .o_io_oe, .o_out_taken, .o_instr_data, .o_instr_valid,
    .o_instr_active, .o_hold, .o_powered, .o_pe_allowed, .o_pe_start);
  sfpc_host_model sfpc_host_model_i (.i_io(io), .o_cs_n(h_cs_n), .o_sck(h_sck), .o_io(h_io), .o_io_oe(h_oe));
  function automatic logic [3:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[3:0] ^ lfsr[11:8];
  endfunction
  function automatic logic [3:0] exp_oe(sfpc_pkg::sfpc_phase_t p);
    case (p)
      sfpc_pkg::PH_SINGLE_OUT, sfpc_pkg::PH_DDR_SINGLE_OUT: return sfpc_pkg::OE_SO;
      sfpc_pkg::PH_DUAL_OUT, sfpc_pkg::PH_DDR_DUAL_OUT: return sfpc_pkg::OE_DUAL;
      sfpc_pkg::PH_QUAD_OUT, sfpc_pkg::PH_DDR_QUAD_OUT: return sfpc_pkg::OE_QUAD;
      default: return sfpc_pkg::OE_NONE;
    endcase
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(negedge i_clk) if (o_out_taken) begin
    n_taken++;
    check(o_io_out, i_out_data);
  end
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  // Far beyond the expected run of about 5 us
  initial begin
    #200000;
    num_errors++;
    results();
  end
  initial begin
    i_rst_n = 1'b0;
    hw_rst_n = 1'b1;
    i_quad_enable = 1'b1;
    i_pe_request = 1'b0;
    i_instr_ready = 1'b0;
    i_out_data = 4'h0;
    i_phase = sfpc_pkg::PH_STANDBY;
    i_supply = '0;
    cyc(10);
    check(o_io_oe, 8'h00);
    i_rst_n = 1'b1;
    cyc(12);
    check(o_powered, 1'b1);
    b1 = {rnd(), rnd()};
    sfpc_host_model_i.frame(1'b1);
    cyc(8);
    check(o_instr_active, 1'b1);
    sfpc_host_model_i.instr(b1);
    cyc(1);
    for (int k = 1; k <= 17; k++) begin
      i_phase = sfpc_pkg::sfpc_phase_t'(k);
      i_out_data = rnd();
      sfpc_host_model_i.xfer(rnd(), exp_oe(i_phase) == sfpc_pkg::OE_NONE ? 4'hF : 4'h0, q);
      cyc(1);
      check(o_io_oe, exp_oe(i_phase));
    end
    check(8'(n_taken > 5), 8'h01);
    sfpc_host_model_i.frame(1'b0);
    cyc(8);
    check(o_instr_active, 1'b0);
    b2 = {rnd(), rnd()};
    sfpc_host_model_i.frame(1'b1);
    sfpc_host_model_i.instr(b2);
    cyc(1);
    i_phase = sfpc_pkg::PH_SINGLE_OUT;
    i_quad_enable = 1'b0;
    sfpc_host_model_i.set(4'h0, 4'h8);
    cyc(8);
    check({o_hold, o_io_oe}, 8'h10);
    sfpc_host_model_i.set(4'h8, 4'h8);
    cyc(8);
    check({o_hold, o_io_oe}, {4'h0, sfpc_pkg::OE_SO});
    i_quad_enable = 1'b1;
    sfpc_host_model_i.frame(1'b0);
    cyc(8);
    $display("phase and pause test done");
    check({o_instr_valid, o_instr_data}, {1'b1, b1});
    i_instr_ready = 1'b1;
    cyc(1);
    check({o_instr_valid, o_instr_data}, {1'b1, b2});
    cyc(1);
    i_instr_ready = 1'b0;
    check(o_instr_valid, 1'b0);
    i_supply.vcc_cutoff = 1'b1;
    i_pe_request = 1'b1;
    sfpc_host_model_i.frame(1'b1);
    cyc(10);
    check({o_instr_active, o_pe_start}, 8'h00);
    sfpc_host_model_i.frame(1'b0);
    cyc(1);
    i_supply.vcc_cutoff = 1'b0;
    cyc(10);
    check(o_pe_start, 1'b1);
    for (int k = 0; k < 16; k++) begin
      q = rnd();
      i_pe_request = q[0];
      cyc(1);
      check(o_pe_start, q[0]);
    end
    i_supply.vcc_low = 1'b1;
    cyc(10);
    check({o_powered, o_pe_start, o_io_oe}, 8'h00);
    i_supply.vcc_low = 1'b0;
    hw_rst_n = 1'b0;
    cyc(10);
    check({o_powered, o_io_oe}, 8'h00);
    $display("supply test done");
    results();
  end
endmodule
